// file: include/tcfc_pkg.sv
/*
 * tcfc_pkg: register map, field positions, reset values and encodings for the
 * timer capture and flip-flop control channel.
 * Assumes a 32-bit word-addressed register bus with byte addresses.
 */
package tcfc_pkg;
    // register byte offsets
    localparam logic [5:0] OFS_ENABLE = 6'h00;
    localparam logic [5:0] OFS_RUN = 6'h04;
    localparam logic [5:0] OFS_MODE = 6'h0c;
    localparam logic [5:0] OFS_FLOP = 6'h10;
    localparam logic [5:0] OFS_STATUS = 6'h14;
    localparam logic [5:0] OFS_MASK = 6'h18;
    localparam logic [5:0] OFS_COUNT = 6'h1c;
    localparam logic [5:0] OFS_CMP0 = 6'h20;
    localparam logic [5:0] OFS_CMP1 = 6'h24;
    localparam logic [5:0] OFS_CAP0 = 6'h28;
    localparam logic [5:0] OFS_CAP1 = 6'h2c;

    // field positions
    localparam int BIT_ENABLE = 7;
    localparam int BIT_PRESC_RUN = 2;
    localparam int BIT_COUNT_RUN = 0;
    localparam int BIT_SW_CAPTURE = 5;
    localparam int POS_EDGE_SEL = 3;
    localparam int BIT_CLEAR_EN = 2;
    localparam int POS_CLK_SEL = 0;
    localparam int BIT_CAP1_TGL = 5;
    localparam int BIT_CAP0_TGL = 4;
    localparam int BIT_MATCH1_TGL = 3;
    localparam int BIT_MATCH0_TGL = 2;
    localparam int POS_FLOP_CMD = 0;
    localparam int BIT_ST_OVF = 2;
    localparam int BIT_ST_MATCH1 = 1;
    localparam int BIT_ST_MATCH0 = 0;

    // fixed read-back patterns
    localparam logic [7:0] FLOP_FIXED_ONES = 8'hc3;
    localparam logic [7:0] MODE_FIXED_ONES = 8'h20;

    // reset values
    localparam logic [3:0] RST_FLOP_EN = 4'h0;
    localparam logic [1:0] RST_EDGE_SEL = 2'h0;
    localparam logic [1:0] RST_CLK_SEL = 2'h0;
    localparam logic [15:0] RST_WORD = 16'h0000;

    // prescaler tap masks
    localparam logic [3:0] PRESC_DIV4_MASK = 4'h3;
    localparam logic [3:0] PRESC_DIV16_MASK = 4'hf;

    typedef enum logic [1:0] {
        EDGE_OFF = 2'b00,
        EDGE_PINS = 2'b01,
        EDGE_PIN0_BOTH = 2'b10,
        EDGE_SIBLING = 2'b11
    } tcfc_edge_type;

    typedef enum logic [1:0] {
        CLK_PIN0 = 2'b00,
        CLK_DIV1 = 2'b01,
        CLK_DIV4 = 2'b10,
        CLK_DIV16 = 2'b11
    } tcfc_clk_type;

    typedef enum logic [1:0] {
        CMD_INVERT = 2'b00,
        CMD_SET = 2'b01,
        CMD_CLEAR = 2'b10,
        CMD_NONE = 2'b11
    } tcfc_cmd_type;
endpackage

// file: rtl/tcfc_timer_channel.sv
/*
 * tcfc_timer_channel: one 16-bit up-counting timer channel with capture mode
 * control, match clearing and a timer flip-flop, behind an Avalon-MM slave.
 * Assumes pins timerInputZero, timerInputOne and siblingMatchOutput are
 * asynchronous to sys_clk and are held at least two clocks per level.
 */
// The Avalon-MM slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module tcfc_timer_channel
    import tcfc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // pins
    input wire logic timerInputZero,
    input wire logic timerInputOne,
    input wire logic siblingMatchOutput,
    output logic timerOut,
    output logic irq
);
    logic [2:0] pinMeta_q;
    logic [2:0] pinSync_q;
    logic [2:0] pinPrev_q;
    logic enable_q;
    logic prescRun_q;
    logic countRun_q;
    logic [1:0] edgeSel_q;
    logic match1ClearEnable_q;
    logic [1:0] clkSel_q;
    logic [3:0] flopEn_q;
    logic [2:0] status_q;
    logic [2:0] mask_q;
    logic [15:0] counter_q;
    logic [15:0] cmp0_q;
    logic [15:0] cmp1_q;
    logic [15:0] cap0_q;
    logic [15:0] cap1_q;
    logic [3:0] presc_q;
    logic timerFlop_q;
    logic waitReq_q;
    logic [31:0] readData_q;
    logic irq_q;
    logic [31:0] readData_d;
    logic access;
    logic wrAccept;
    logic rdAccept;
    logic regOpen;
    logic countTick;
    logic match0;
    logic match1;
    logic overflow;
    logic cap0Load;
    logic cap1Load;
    logic hwCap0;
    logic hwCap1;
    logic swCapture;
    logic toggle;
    logic [2:0] rise;
    logic [2:0] fall;

    // helper for register write decode
    function automatic logic hit(input logic [5:0] adr, input logic [5:0] ofs);
        hit = (adr[5:2] == ofs[5:2]);
    endfunction

    // bus phases: answer one cycle after the request, write at the acknowledge edge
    assign access = (read | write) & ~waitReq_q;
    assign wrAccept = write & ~waitReq_q;
    assign rdAccept = read & ~waitReq_q;
    assign regOpen = enable_q;

    // two-flop synchronisers, then a third stage for edge detection
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pinMeta_q <= 3'h0;
            pinSync_q <= 3'h0;
            pinPrev_q <= 3'h0;
        end else begin
            pinMeta_q <= {siblingMatchOutput, timerInputOne, timerInputZero};
            pinSync_q <= pinMeta_q;
            pinPrev_q <= pinSync_q;
        end
    end
    assign rise = pinSync_q & ~pinPrev_q;
    assign fall = ~pinSync_q & pinPrev_q;

    // prescaler, stopped and cleared when its run bit is low
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            presc_q <= 4'h0;
        end else if (!enable_q) begin
            presc_q <= presc_q;
        end else if (!prescRun_q) begin
            presc_q <= 4'h0;
        end else begin
            presc_q <= presc_q + 4'h1;
        end
    end

    // count clock source selection
    always_comb begin
        unique case (tcfc_clk_type'(clkSel_q))
            CLK_PIN0: countTick = rise[0];
            CLK_DIV1: countTick = prescRun_q;
            CLK_DIV4: countTick = prescRun_q & ((presc_q & PRESC_DIV4_MASK) == PRESC_DIV4_MASK);
            CLK_DIV16: countTick = prescRun_q & (presc_q == PRESC_DIV16_MASK);
        endcase
    end

    // match and overflow events, one per counter tick
    assign match0 = enable_q & countRun_q & countTick & (counter_q == cmp0_q);
    assign match1 = enable_q & countRun_q & countTick & (counter_q == cmp1_q);
    assign overflow = enable_q & countRun_q & countTick & (counter_q == 16'hffff) & ~(match1 & match1ClearEnable_q);

    // up-counter with optional clear on compare one
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            counter_q <= RST_WORD;
        end else if (!enable_q) begin
            counter_q <= counter_q;
        end else if (!countRun_q) begin
            counter_q <= RST_WORD;
        end else if (match1 && match1ClearEnable_q) begin
            counter_q <= RST_WORD;
        end else if (countTick) begin
            counter_q <= counter_q + 16'h0001;
        end
    end

    // capture triggers by edge select mode
    always_comb begin
        hwCap0 = 1'b0;
        hwCap1 = 1'b0;
        unique case (tcfc_edge_type'(edgeSel_q))
            EDGE_OFF: begin
                hwCap0 = 1'b0;
                hwCap1 = 1'b0;
            end
            EDGE_PINS: begin
                hwCap0 = rise[0];
                hwCap1 = rise[1];
            end
            EDGE_PIN0_BOTH: begin
                hwCap0 = rise[0];
                hwCap1 = fall[0];
            end
            EDGE_SIBLING: begin
                hwCap0 = rise[2];
                hwCap1 = fall[2];
            end
        endcase
    end
    assign swCapture = wrAccept & regOpen & hit(address, OFS_MODE) & ~writedata[BIT_SW_CAPTURE];
    assign cap0Load = enable_q & (hwCap0 | swCapture);
    assign cap1Load = enable_q & hwCap1;

    // capture registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cap0_q <= RST_WORD;
            cap1_q <= RST_WORD;
        end else begin
            if (cap0Load) begin
                cap0_q <= counter_q;
            end
            if (cap1Load) begin
                cap1_q <= counter_q;
            end
        end
    end

    // parity of all enabled capture and match triggers in this cycle, software capture included
    assign toggle = (cap1Load & flopEn_q[3])
        ^ (cap0Load & flopEn_q[2])
        ^ (match1 & flopEn_q[1])
        ^ (match0 & flopEn_q[0]);

    // timer flop: software set or clear wins, software invert joins the parity
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            timerFlop_q <= 1'b0;
        end else if (wrAccept && regOpen && hit(address, OFS_FLOP)) begin
            unique case (tcfc_cmd_type'(writedata[POS_FLOP_CMD +: 2]))
                CMD_INVERT: timerFlop_q <= ~timerFlop_q ^ toggle;
                CMD_SET: timerFlop_q <= 1'b1;
                CMD_CLEAR: timerFlop_q <= 1'b0;
                CMD_NONE: timerFlop_q <= timerFlop_q ^ toggle;
            endcase
        end else begin
            timerFlop_q <= timerFlop_q ^ toggle;
        end
    end

    // enable register, always reachable
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            enable_q <= 1'b0;
        end else if (wrAccept && hit(address, OFS_ENABLE)) begin
            enable_q <= writedata[BIT_ENABLE];
        end
    end

    // control registers, reachable only while enabled
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prescRun_q <= 1'b0;
            countRun_q <= 1'b0;
            edgeSel_q <= RST_EDGE_SEL;
            match1ClearEnable_q <= 1'b0;
            clkSel_q <= RST_CLK_SEL;
            flopEn_q <= RST_FLOP_EN;
            mask_q <= 3'h0;
            cmp0_q <= RST_WORD;
            cmp1_q <= RST_WORD;
        end else if (wrAccept && regOpen) begin
            if (hit(address, OFS_RUN)) begin
                prescRun_q <= writedata[BIT_PRESC_RUN];
                countRun_q <= writedata[BIT_COUNT_RUN];
            end
            if (hit(address, OFS_MODE)) begin
                edgeSel_q <= writedata[POS_EDGE_SEL +: 2];
                match1ClearEnable_q <= writedata[BIT_CLEAR_EN];
                clkSel_q <= writedata[POS_CLK_SEL +: 2];
            end
            if (hit(address, OFS_FLOP)) begin
                flopEn_q <= writedata[BIT_MATCH0_TGL +: 4];
            end
            if (hit(address, OFS_MASK)) begin
                mask_q <= writedata[2:0];
            end
            if (hit(address, OFS_CMP0)) begin
                cmp0_q <= writedata[15:0];
            end
            if (hit(address, OFS_CMP1)) begin
                cmp1_q <= writedata[15:0];
            end
        end
    end

    // sticky flags: set regardless of mask, cleared by status read or write-one, set wins
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            status_q <= 3'h0;
        end else begin
            status_q <= (status_q
                & ~((rdAccept && regOpen && hit(address, OFS_STATUS)) ? 3'h7 : 3'h0)
                & ~((wrAccept && regOpen && hit(address, OFS_STATUS)) ? writedata[2:0] : 3'h0))
                | {overflow, match1, match0};
        end
    end

    // level interrupt from unmasked flags
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(status_q & mask_q);
        end
    end

    // read multiplexer
    always_comb begin
        readData_d = 32'h0000_0000;
        if (hit(address, OFS_ENABLE)) begin
            readData_d[BIT_ENABLE] = enable_q;
        end else if (regOpen) begin
            unique case (address[5:2])
                OFS_RUN[5:2]: begin
                    readData_d[BIT_PRESC_RUN] = prescRun_q;
                    readData_d[BIT_COUNT_RUN] = countRun_q;
                end
                OFS_MODE[5:2]: begin
                    readData_d[7:0] = MODE_FIXED_ONES;
                    readData_d[POS_EDGE_SEL +: 2] = edgeSel_q;
                    readData_d[BIT_CLEAR_EN] = match1ClearEnable_q;
                    readData_d[POS_CLK_SEL +: 2] = clkSel_q;
                end
                OFS_FLOP[5:2]: begin
                    readData_d[7:0] = FLOP_FIXED_ONES;
                    readData_d[BIT_MATCH0_TGL +: 4] = flopEn_q;
                end
                OFS_STATUS[5:2]: readData_d[2:0] = status_q;
                OFS_MASK[5:2]: readData_d[2:0] = mask_q;
                OFS_COUNT[5:2]: readData_d[15:0] = counter_q;
                OFS_CMP0[5:2]: readData_d[15:0] = cmp0_q;
                OFS_CMP1[5:2]: readData_d[15:0] = cmp1_q;
                OFS_CAP0[5:2]: readData_d[15:0] = cap0_q;
                OFS_CAP1[5:2]: readData_d[15:0] = cap1_q;
                default: readData_d = 32'h0000_0000;
            endcase
        end
    end

    // waitrequest: low for exactly one cycle per request
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            waitReq_q <= 1'b1;
            readData_q <= 32'h0000_0000;
        end else if (access) begin
            waitReq_q <= 1'b1;
        end else if (read || write) begin
            waitReq_q <= 1'b0;
            readData_q <= readData_d;
        end
    end

    // outputs
    assign readdata = readData_q;
    assign waitrequest = waitReq_q;
    assign timerOut = timerFlop_q;
    assign irq = irq_q;

    // assertions
    AST_SWCAP: assert property (@(posedge sys_clk) disable iff (rst)
        swCapture |=> cap0_q == $past(counter_q))
        else $error("software capture did not load capture zero");
    AST_NOCAP: assert property (@(posedge sys_clk) disable iff (rst)
        (edgeSel_q == EDGE_OFF && !swCapture) |=> $stable(cap0_q) && $stable(cap1_q))
        else $error("capture taken with edge select off");
    AST_PINS: assert property (@(posedge sys_clk) disable iff (rst)
        (enable_q && edgeSel_q == EDGE_PINS && rise[1]) |=> cap1_q == $past(counter_q))
        else $error("pin one rising did not capture");
    AST_FALL: assert property (@(posedge sys_clk) disable iff (rst)
        (enable_q && edgeSel_q == EDGE_PIN0_BOTH && fall[0]) |=> cap1_q == $past(counter_q))
        else $error("pin zero falling did not capture");
    AST_SIB: assert property (@(posedge sys_clk) disable iff (rst)
        (enable_q && edgeSel_q == EDGE_SIBLING && rise[2]) |=> cap0_q == $past(counter_q))
        else $error("sibling rising did not capture");
    AST_CLEAR: assert property (@(posedge sys_clk) disable iff (rst)
        (match1 && match1ClearEnable_q) |=> counter_q == 16'h0000)
        else $error("counter not cleared on compare one");
    AST_NOCLEAR: assert property (@(posedge sys_clk) disable iff (rst)
        (match1 && !match1ClearEnable_q && countRun_q) |=> counter_q == $past(counter_q) + 16'h0001)
        else $error("counter cleared without clear enable");
    AST_DIV16: assert property (@(posedge sys_clk) disable iff (rst)
        (enable_q && clkSel_q == CLK_DIV16 && countTick) |=> !countTick)
        else $error("divide by 16 ticked twice in a row");
    AST_TGL: assert property (@(posedge sys_clk) disable iff (rst)
        (match1 && flopEn_q[1] && !match0 && !cap0Load && !cap1Load && !wrAccept) |=> timerOut != $past(timerOut))
        else $error("match one did not invert the flop");
    AST_SET: assert property (@(posedge sys_clk) disable iff (rst)
        (wrAccept && regOpen && hit(address, OFS_FLOP) && writedata[1:0] == CMD_SET) |=> timerOut)
        else $error("set command did not set the flop");
    AST_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
        !enable_q |=> $stable(counter_q) && $stable(cmp0_q) && $stable(cap1_q))
        else $error("disabled channel changed state");
    AST_FLAG: assert property (@(posedge sys_clk) disable iff (rst)
        match0 |=> status_q[BIT_ST_MATCH0])
        else $error("match zero flag lost");
    AST_ACK: assert property (@(posedge sys_clk) disable iff (rst)
        (read || write) && waitReq_q |=> !waitReq_q)
        else $error("slave did not answer in one cycle");
    COV_CAP: cover property (@(posedge sys_clk) disable iff (rst) cap1Load && flopEn_q[3]);
    COV_CLR: cover property (@(posedge sys_clk) disable iff (rst) match1 && match1ClearEnable_q);
    COV_IRQ: cover property (@(posedge sys_clk) disable iff (rst) irq_q ##1 !irq_q);
endmodule // tcfc_timer_channel

// file: testbench/tb_tcfc_timer_channel.sv
/*
 * tb_tcfc_timer_channel: self-checking bench for the timer channel.
 * Assumes one low cycle of waitrequest per access and the pin model as far side.
 */
`timescale 1ns/1ps
module tb_tcfc_timer_channel
    import tcfc_pkg::*;
;
    logic sys_clk, rst, read, write, waitrequest, timerOut, irq;
    logic [5:0] address;
    logic [31:0] writedata, readdata, rd;
    logic timerInputZero, timerInputOne, siblingMatchOutput;
    int errors = 0;
    int comparisons = 0;

    // free-running 100 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    tcfc_timer_channel tcfc_timer_channel_inst (.sys_clk(sys_clk), .rst(rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .timerInputZero(timerInputZero), .timerInputOne(timerInputOne),
        .siblingMatchOutput(siblingMatchOutput), .timerOut(timerOut), .irq(irq));
    tcfc_pin_model tcfc_pin_model_inst (.sys_clk(sys_clk), .timerInputZero(timerInputZero),
        .timerInputOne(timerInputOne), .siblingMatchOutput(siblingMatchOutput));

    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one avalon access held until waitrequest is sampled low
    // no local limit: only the watchdog ends a wait that never gets its answer
    task automatic access(input logic [5:0] a, input logic wr, input logic [31:0] d);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= ~wr;
        do begin
            @(posedge sys_clk);
        end while (waitrequest !== 1'b0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        access(a, 1'b1, d);
    endtask

    task automatic expect_reg(input logic [5:0] a, input logic [31:0] exp);
        access(a, 1'b0, 32'h0);
        check(rd, exp);
    endtask

    task automatic pulse(input int sel);
        tcfc_pin_model_inst.pulse(sel, 6);
    endtask

    // access refused while disabled, fixed read-back patterns once enabled
    task automatic sc_reset_access();
        expect_reg(OFS_MODE, 32'h0);
        wr(OFS_ENABLE, 32'h80);
        expect_reg(OFS_MODE, 32'h20);
        expect_reg(OFS_FLOP, 32'hc3);
        expect_reg(6'h08, 32'h0);
    endtask

    // counting pin zero edges, software capture on writing zero only
    task automatic sc_sw_capture();
        wr(OFS_RUN, 32'h1);
        repeat (3) pulse(0);
        expect_reg(OFS_COUNT, 32'h3);
        expect_reg(OFS_CAP0, 32'h0);
        wr(OFS_MODE, 32'h0);
        expect_reg(OFS_CAP0, 32'h3);
        expect_reg(OFS_MODE, 32'h20);
        pulse(0);
        wr(OFS_MODE, 32'h20);
        expect_reg(OFS_CAP0, 32'h3);
    endtask

    // hardware capture sources with capture toggles on the flop
    task automatic sc_edges();
        wr(OFS_FLOP, 32'h33);
        wr(OFS_MODE, 32'h28);
        pulse(0);
        expect_reg(OFS_CAP0, 32'h4);
        check({31'h0, timerOut}, 32'h1);
        pulse(1);
        expect_reg(OFS_CAP1, 32'h5);
        check({31'h0, timerOut}, 32'h0);
        wr(OFS_MODE, 32'h30);
        pulse(0);
        expect_reg(OFS_CAP0, 32'h5);
        expect_reg(OFS_CAP1, 32'h6);
        check({31'h0, timerOut}, 32'h0);
        wr(OFS_MODE, 32'h38);
        wr(OFS_FLOP, 32'h03);
        pulse(2);
        expect_reg(OFS_CAP0, 32'h6);
        expect_reg(OFS_COUNT, 32'h6);
    endtask

    // software commands set, clear, invert and no-op
    task automatic sc_flop_cmds();
        logic [1:0] cmd [5] = '{2'h1, 2'h0, 2'h0, 2'h3, 2'h2};
        logic res [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
        for (int i = 0; i < 5; i++) begin
            wr(OFS_FLOP, {30'h0, cmd[i]});
            check({31'h0, timerOut}, {31'h0, res[i]});
        end
        expect_reg(OFS_FLOP, 32'hc3);
    endtask

    // matches, clear on compare one, flags, mask and interrupt
    task automatic sc_match();
        wr(OFS_CMP0, 32'h1);
        wr(OFS_CMP1, 32'h2);
        wr(OFS_FLOP, 32'h0f);
        wr(OFS_MASK, 32'h2);
        wr(OFS_MODE, 32'h24);
        wr(OFS_RUN, 32'h0);
        wr(OFS_RUN, 32'h1);
        access(OFS_STATUS, 1'b0, 32'h0);
        repeat (2) pulse(0);
        check({31'h0, timerOut}, 32'h1);
        pulse(0);
        check({31'h0, timerOut}, 32'h0);
        check({31'h0, irq}, 32'h1);
        expect_reg(OFS_COUNT, 32'h0);
        expect_reg(OFS_STATUS, 32'h3);
        expect_reg(OFS_STATUS, 32'h0);
        check({31'h0, irq}, 32'h0);
        wr(OFS_MASK, 32'h0);
        wr(OFS_MODE, 32'h20);
        repeat (3) pulse(0);
        expect_reg(OFS_COUNT, 32'h3);
        check({31'h0, irq}, 32'h0);
        wr(OFS_STATUS, 32'h2);
        wr(OFS_MASK, 32'h1);
        expect_reg(OFS_COUNT, 32'h3);
        check({31'h0, irq}, 32'h1);
        expect_reg(OFS_STATUS, 32'h1);
        wr(OFS_ENABLE, 32'h0);
        wr(OFS_CMP1, 32'h5);
        expect_reg(OFS_CMP1, 32'h0);
        wr(OFS_ENABLE, 32'h80);
        expect_reg(OFS_CMP1, 32'h2);
    endtask

    // prescaler taps: about 162 cycles of counting per source
    task automatic sc_prescale();
        int dv [3] = '{1, 4, 16};
        int e;
        wr(OFS_FLOP, 32'h03);
        for (int i = 0; i < 3; i++) begin
            e = 162 / dv[i];
            wr(OFS_RUN, 32'h0);
            wr(OFS_MODE, 32'h20 | 32'(i + 1));
            wr(OFS_RUN, 32'h5);
            repeat (160) @(posedge sys_clk);
            access(OFS_COUNT, 1'b0, 32'h0);
            check({31'h0, (int'(rd) >= e - 4) && (int'(rd) <= e + 4)}, 32'h1);
        end
    endtask

    // verdict and end of run
    task automatic give_verdict();
        if (errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // watchdog against a hung handshake
    initial begin
        #200000;
        errors++;
        give_verdict();
    end

    // reset then scenarios
    initial begin
        rst = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 6'h00;
        writedata = 32'h0;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        sc_reset_access();
        sc_sw_capture();
        sc_edges();
        sc_flop_cmds();
        sc_match();
        sc_prescale();
        give_verdict();
    end
endmodule // tb_tcfc_timer_channel

// file: testbench/tcfc_pin_model.sv
/*
 * tcfc_pin_model: drives the two capture pins and the sibling match output.
 * Assumes the channel samples these pins through a short synchroniser on sys_clk.
 */
`timescale 1ns/1ps
module tcfc_pin_model (
    // clock
    input wire logic sys_clk,
    // driven pins
    output logic timerInputZero,
    output logic timerInputOne,
    output logic siblingMatchOutput
);
    // pins idle low from time zero
    initial begin
        timerInputZero = 1'b0;
        timerInputOne = 1'b0;
        siblingMatchOutput = 1'b0;
    end

    // move one pin just after a clock edge
    task automatic drive(input int sel, input logic v);
        case (sel)
            0: timerInputZero <= v;
            1: timerInputOne <= v;
            default: siblingMatchOutput <= v;
        endcase
    endtask

    // one pulse; each level outlasts the synchroniser delay
    task automatic pulse(input int sel, input int hold);
        drive(sel, 1'b1);
        repeat (hold) @(posedge sys_clk);
        drive(sel, 1'b0);
        repeat (hold) @(posedge sys_clk);
    endtask
endmodule // tcfc_pin_model
